//--- verilog/fces_chip_erase.sv
`timescale 1ns/1ps
// Function
// - chip erase starts only while the write enable latch is set
// - opcodes 60h and c7h both start the same chip erase
// - chip erase takes no address; trailing bytes are ignored
// - erase runs self-timed after chip select rises, up to chip erase time
// - chip select released off a byte boundary cancels chip erase
// - any protected or locked sector rejects chip erase, back to idle
// - rejected chip erase clears the write enable latch
// - busy shown during erase; latch cleared before it ends
// - erase failure sets the erase/program error flag
// - suspend opcode b0h takes no address; trailing bytes ignored
// - suspend acts regardless of the write enable latch
// - suspend halts the running operation within suspend latency
// - halted operation sets program or erase suspended flag, shows ready
// - suspend with chip select off a byte boundary does nothing
// - erase suspend still allows reads and status reads; programs elsewhere only when the suspended erase is not a chip erase
// - reads in a suspended sector return undefined data
// - program into erase-suspended sector aborts and clears latch
// - block erase into program-suspended sector aborts and clears latch
// - program in another sector during erase suspend may itself suspend
// - reset in erase suspend cancels it; block left undefined
// - reset in program suspend cancels it; only that page undefined
// - disallowed commands while suspended are ignored, flags kept
module fces_chip_erase #(
    parameter int ERASE_CYCLES = fces_pkg::CHIP_ERASE_CYCLES,
    parameter int SUSP_CYCLES = fces_pkg::SUSPEND_CYCLES,
    parameter int PROG_CYCLES = 2500
)(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic spi_sck,
    input wire logic spi_cs_b,
    input wire logic spi_si,
    input wire logic any_sector_protected,
    input wire logic any_sector_locked,
    input wire logic erase_fail,
    input wire logic program_fail,
    input wire logic soft_reset,
    input wire logic [fces_pkg::SECTOR_BITS-1:0] read_sector,
    output logic write_enable_latch,
    output logic ready_busy_flag,
    output logic erase_program_error_flag,
    output logic program_suspended_flag,
    output logic erase_suspended_flag,
    output logic protection_registers_locked_flag,
    output logic lockdown_enabled_flag,
    output logic array_erasing,
    output logic read_data_undefined,
    output logic sector_contents_undefined,
    output logic page_contents_undefined
);

    // ****************************************************************
    // pin synchronisers and serial capture
    // ****************************************************************
    logic [1:0] sck_s_q;
    logic [1:0] cs_s_q;
    logic [1:0] si_s_q;
    logic sck_prev_q;
    logic cs_prev_q;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sck_s_q <= 2'h0;
            cs_s_q <= 2'h3;
            si_s_q <= 2'h0;
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end
        else
        begin
            sck_s_q <= {sck_s_q[0], spi_sck};
            cs_s_q <= {cs_s_q[0], spi_cs_b};
            si_s_q <= {si_s_q[0], spi_si};
            sck_prev_q <= sck_s_q[1];
            cs_prev_q <= cs_s_q[1];
        end
    end

    logic sck_rise;
    logic cs_rise;
    logic cs_active;
    assign sck_rise = sck_s_q[1] && !sck_prev_q;
    assign cs_rise = cs_s_q[1] && !cs_prev_q;
    assign cs_active = !cs_s_q[1];
    // bits counted modulo 8; the opcode is the first byte, the next byte gives the sector, later bytes only counted
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] opcode_q;
    logic have_op_q;
    logic [fces_pkg::SECTOR_BITS-1:0] addr_sector_q;
    logic [1:0] byte_idx_q;
    logic [7:0] next_shift;
    assign next_shift = {shift_q[6:0], si_s_q[1]};

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            opcode_q <= 8'h00;
            have_op_q <= 1'b0;
            byte_idx_q <= 2'h0;
            addr_sector_q <= fces_pkg::RST_SECTOR;
        end
        else if (!cs_active)
        begin
            bit_cnt_q <= 3'h0;
            have_op_q <= 1'b0;
            byte_idx_q <= 2'h0;
        end
        else if (sck_rise)
        begin
            shift_q <= next_shift;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7)
            begin
                if (!have_op_q)
                begin
                    opcode_q <= next_shift;
                    have_op_q <= 1'b1;
                end
                else if (byte_idx_q != 2'h3)
                begin
                    byte_idx_q <= byte_idx_q + 2'h1;
                    if (byte_idx_q == 2'h0)
                    begin
                        addr_sector_q <= next_shift[fces_pkg::SECTOR_BITS-1:0];
                    end
                end
            end
        end
    end

    // starts, suspend and latch commands only count on a clean byte boundary; rejects and aborts act off it too
    logic cmd_end;
    logic byte_ok;
    assign cmd_end = cs_rise && have_op_q;
    assign byte_ok = (bit_cnt_q == 3'h0);
    function automatic logic is_chip_erase(input logic [7:0] op);
        is_chip_erase = (op == fces_pkg::OP_CHIP_ERASE_A) || (op == fces_pkg::OP_CHIP_ERASE_B);
    endfunction : is_chip_erase
    function automatic logic is_program(input logic [7:0] op);
        is_program = (op == fces_pkg::OP_PAGE_PROGRAM) || (op == fces_pkg::OP_DUAL_PROGRAM);
    endfunction : is_program
    function automatic logic is_block_erase(input logic [7:0] op);
        is_block_erase = (op == fces_pkg::OP_ERASE_4K) || (op == fces_pkg::OP_ERASE_32K)
            || (op == fces_pkg::OP_ERASE_64K);
    endfunction : is_block_erase

    // ****************************************************************
    // operation sequencer
    // ****************************************************************
    typedef enum logic [2:0] {
        FCES_IDLE = 3'b000,
        FCES_ERASE = 3'b001,
        FCES_PROG = 3'b010,
        FCES_SUSP_WAIT = 3'b011
    } fces_state_e;
    fces_state_e state_q;
    logic [31:0] timer_q;
    logic susp_target_erase_q;
    logic [fces_pkg::SECTOR_BITS-1:0] erase_sector_q;
    logic [fces_pkg::SECTOR_BITS-1:0] prog_sector_q;
    logic erase_susp_q;
    logic prog_susp_q;
    logic erase_chip_q;
    logic busy;
    assign busy = (state_q != FCES_IDLE);
    // any suspension blocks chip erase: it is neither started nor rejected
    logic any_susp;
    assign any_susp = erase_susp_q || prog_susp_q;
    logic ce_go;
    logic ce_reject;
    logic susp_go;
    logic prog_start;
    logic prog_abort;
    logic blk_abort;
    assign ce_go = cmd_end && byte_ok && is_chip_erase(opcode_q) && !busy && !any_susp
        && write_enable_latch && !any_sector_protected && !any_sector_locked;
    assign ce_reject = cmd_end && is_chip_erase(opcode_q) && !busy && !any_susp
        && write_enable_latch && (!byte_ok || any_sector_protected || any_sector_locked);
    assign susp_go = cmd_end && byte_ok && (opcode_q == fces_pkg::OP_SUSPEND)
        && (state_q == FCES_ERASE || state_q == FCES_PROG);
    assign prog_start = cmd_end && byte_ok && is_program(opcode_q) && !busy && erase_susp_q
        && !prog_susp_q && write_enable_latch && (byte_idx_q == 2'h3) && !erase_chip_q
        && (addr_sector_q != erase_sector_q);
    assign prog_abort = cmd_end && is_program(opcode_q) && !busy && erase_susp_q
        && (erase_chip_q || addr_sector_q == erase_sector_q);
    assign blk_abort = cmd_end && is_block_erase(opcode_q) && !busy && prog_susp_q
        && (addr_sector_q == prog_sector_q);

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= FCES_IDLE;
            timer_q <= 32'h0;
            susp_target_erase_q <= 1'b0;
            erase_susp_q <= 1'b0;
            prog_susp_q <= 1'b0;
            erase_chip_q <= 1'b0;
            erase_sector_q <= fces_pkg::RST_SECTOR;
            prog_sector_q <= fces_pkg::RST_SECTOR;
        end
        else if (soft_reset)
        begin
            state_q <= FCES_IDLE;
            erase_susp_q <= 1'b0;
            prog_susp_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                FCES_IDLE:
                begin
                    if (ce_go)
                    begin
                        state_q <= FCES_ERASE;
                        timer_q <= 32'(ERASE_CYCLES);
                        erase_chip_q <= 1'b1;
                    end
                    else if (prog_start)
                    begin
                        state_q <= FCES_PROG;
                        timer_q <= 32'(PROG_CYCLES);
                        prog_sector_q <= addr_sector_q;
                    end
                end
                FCES_ERASE, FCES_PROG:
                begin
                    if (susp_go)
                    begin
                        state_q <= FCES_SUSP_WAIT;
                        susp_target_erase_q <= (state_q == FCES_ERASE);
                        timer_q <= 32'(SUSP_CYCLES);
                    end
                    else if (timer_q <= 32'h1)
                        state_q <= FCES_IDLE;
                    else
                    begin
                        timer_q <= timer_q - 32'h1;
                    end
                end
                FCES_SUSP_WAIT:
                begin
                    // halt only at the end of the latency; the whole latency is waited out here
                    if (timer_q <= 32'h1)
                    begin
                        state_q <= FCES_IDLE;
                        erase_susp_q <= erase_susp_q || susp_target_erase_q;
                        prog_susp_q <= prog_susp_q || !susp_target_erase_q;
                    end
                    else
                    begin
                        timer_q <= timer_q - 32'h1;
                    end
                end
                default:
                    state_q <= FCES_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    logic op_done;
    assign op_done = (state_q == FCES_ERASE || state_q == FCES_PROG) && (timer_q <= 32'h1)
        && !susp_go && !soft_reset;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            write_enable_latch <= fces_pkg::RST_WEL;
        end
        else if (soft_reset)
        begin
            write_enable_latch <= fces_pkg::RST_WEL;
        end
        else if (ce_go || prog_start || ce_reject || prog_abort || blk_abort)
        begin
            write_enable_latch <= 1'b0;
        end
        else if (cmd_end && byte_ok && !busy)
        begin
            // latch commands while suspended only where erase suspend permits them
            if (opcode_q == fces_pkg::OP_WRITE_ENABLE && !prog_susp_q)
            begin
                write_enable_latch <= 1'b1;
            end
            else if (opcode_q == fces_pkg::OP_WRITE_DISABLE && !prog_susp_q)
            begin
                write_enable_latch <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            erase_program_error_flag <= 1'b0;
        end
        else if (op_done && ((state_q == FCES_ERASE && erase_fail)
            || (state_q == FCES_PROG && program_fail)))
        begin
            erase_program_error_flag <= 1'b1;
        end
        else if (ce_go || prog_start)
        begin
            erase_program_error_flag <= 1'b0;
        end
    end

    // lock bits are owned by protection logic elsewhere; registered copies of its inputs here
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ready_busy_flag <= 1'b0;
            program_suspended_flag <= 1'b0;
            erase_suspended_flag <= 1'b0;
            protection_registers_locked_flag <= 1'b0;
            lockdown_enabled_flag <= 1'b0;
            array_erasing <= 1'b0;
            read_data_undefined <= 1'b0;
            sector_contents_undefined <= 1'b0;
            page_contents_undefined <= 1'b0;
        end
        else
        begin
            ready_busy_flag <= busy;
            program_suspended_flag <= prog_susp_q;
            erase_suspended_flag <= erase_susp_q;
            protection_registers_locked_flag <= any_sector_protected;
            lockdown_enabled_flag <= any_sector_locked;
            array_erasing <= (state_q == FCES_ERASE) && erase_chip_q;
            read_data_undefined <= (erase_susp_q && (erase_chip_q || read_sector == erase_sector_q))
                || (prog_susp_q && read_sector == prog_sector_q);
            if (soft_reset && erase_susp_q)
            begin
                sector_contents_undefined <= 1'b1;
            end
            else if (ce_go)
            begin
                sector_contents_undefined <= 1'b0;
            end
            if (soft_reset && prog_susp_q)
            begin
                page_contents_undefined <= 1'b1;
            end
            else if (prog_start)
            begin
                page_contents_undefined <= 1'b0;
            end
        end
    end

endmodule : fces_chip_erase

//--- verilog/fces_pkg.sv
package fces_pkg;

    // ****************************************************************
    // opcodes
    // ****************************************************************
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] OP_SUSPEND = 8'hb0;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_DUAL_PROGRAM = 8'ha2;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hd8;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ = 25;
    localparam int CHIP_ERASE_TIME_US = 1000;
    localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * CLK_MHZ;
    localparam int SUSPEND_LATENCY_US = 20;
    localparam int SUSPEND_CYCLES = SUSPEND_LATENCY_US * CLK_MHZ;
    localparam int SECTOR_BITS = 5;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic RST_WEL = 1'b0;
    localparam logic [SECTOR_BITS-1:0] RST_SECTOR = 5'h00;

endpackage : fces_pkg

//--- sim/fces_chip_erase_chk.sv
`timescale 1ns/1ps
// ****************************************
// chip erase and suspend checker
// ****************************************
module fces_chip_erase_chk #(
    parameter int ERASE_CYCLES = 50
)(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic spi_cs_b,
    input wire logic any_sector_protected,
    input wire logic any_sector_locked,
    input wire logic erase_fail,
    input wire logic soft_reset,
    input wire logic write_enable_latch,
    input wire logic ready_busy_flag,
    input wire logic erase_program_error_flag,
    input wire logic erase_suspended_flag,
    input wire logic protection_registers_locked_flag,
    input wire logic lockdown_enabled_flag,
    input wire logic array_erasing,
    input wire logic sector_contents_undefined
);
    int run_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // counts the length of one erase run
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            run_q <= 0;
        else
            run_q <= array_erasing ? run_q + 1 : 0;
    end
    erase_needs_wel_a: assert property (
        $rose(array_erasing) |-> $past(write_enable_latch) || $past(write_enable_latch, 2))
        else $error("erase started without write enable");
    erase_start_a: assert property (
        $rose(array_erasing) |-> spi_cs_b && !any_sector_protected && !any_sector_locked)
        else $error("erase started while selected or protected");
    erase_busy_a: assert property (
        array_erasing && $past(array_erasing) |-> ready_busy_flag)
        else $error("erase running but ready shown");
    erase_end_wel_a: assert property (
        $fell(array_erasing) |-> !write_enable_latch)
        else $error("write enable still set at erase end");
    erase_length_a: assert property (
        run_q <= ERASE_CYCLES + 1)
        else $error("erase ran past its time");
    erase_error_a: assert property (
        $fell(array_erasing) && $past(erase_fail, 2) && !$past(soft_reset, 2)
        && !ready_busy_flag |-> ##[0:2] erase_program_error_flag)
        else $error("erase failure not flagged");
    susp_ready_a: assert property (
        $rose(erase_suspended_flag) |-> ##[0:2] !ready_busy_flag && !array_erasing)
        else $error("suspended but still busy");
    susp_flags_kept_a: assert property (
        erase_suspended_flag && $past(erase_suspended_flag) |->
        $stable(protection_registers_locked_flag) && $stable(lockdown_enabled_flag))
        else $error("lock flags moved during suspend");
    reset_in_susp_a: assert property (
        soft_reset && erase_suspended_flag |-> ##[1:3] sector_contents_undefined
        && !erase_suspended_flag)
        else $error("reset did not cancel erase suspend");
endmodule : fces_chip_erase_chk

//--- sim/fces_spi_host.sv
`timescale 1ns/1ps
// ****************************************
// host spi controller model, mode 0
// ****************************************
module fces_spi_host (
    input wire logic core_clk,
    output logic spi_sck,
    output logic spi_cs_b,
    output logic spi_si
);
    initial
    begin
        spi_sck = 1'b0;
        spi_cs_b = 1'b1;
        spi_si = 1'b0;
    end
    // d is msb aligned; n off a multiple of eight gives a broken frame
    task automatic send(input logic [15:0] d, input int n);
        @(negedge core_clk);
        spi_cs_b = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            spi_si = d[15-i];
            repeat (4) @(negedge core_clk);
            spi_sck = 1'b1;
            repeat (4) @(negedge core_clk);
            spi_sck = 1'b0;
        end
        repeat (4) @(negedge core_clk);
        spi_cs_b = 1'b1;
        // released line: no pull, so show the inverse of the last bit
        spi_si = ~spi_si;
        repeat (12) @(negedge core_clk);
    endtask : send
endmodule : fces_spi_host

//--- sim/fces_chip_erase_tb.sv
`timescale 1ns/1ps
// ****************************************
// chip erase and suspend bench
// ****************************************
module fces_chip_erase_tb;
    localparam int ERASE_CYCLES = 2000;
    logic core_clk, rst_b, spi_sck, spi_cs_b, spi_si, any_sector_protected, any_sector_locked;
    logic erase_fail, program_fail, soft_reset, write_enable_latch, ready_busy_flag;
    logic erase_program_error_flag, program_suspended_flag, erase_suspended_flag;
    logic protection_registers_locked_flag, lockdown_enabled_flag, array_erasing;
    logic read_data_undefined, sector_contents_undefined, page_contents_undefined;
    logic [fces_pkg::SECTOR_BITS-1:0] read_sector;
    int n_mismatch = 0;
    int cmp_count = 0;
    fces_chip_erase #(.ERASE_CYCLES(ERASE_CYCLES), .SUSP_CYCLES(5), .PROG_CYCLES(20)) u_dut (
        .core_clk(core_clk), .rst_b(rst_b), .spi_sck(spi_sck), .spi_cs_b(spi_cs_b),
        .spi_si(spi_si), .any_sector_protected(any_sector_protected),
        .any_sector_locked(any_sector_locked), .erase_fail(erase_fail),
        .program_fail(program_fail), .soft_reset(soft_reset), .read_sector(read_sector),
        .write_enable_latch(write_enable_latch), .ready_busy_flag(ready_busy_flag),
        .erase_program_error_flag(erase_program_error_flag),
        .program_suspended_flag(program_suspended_flag),
        .erase_suspended_flag(erase_suspended_flag),
        .protection_registers_locked_flag(protection_registers_locked_flag),
        .lockdown_enabled_flag(lockdown_enabled_flag), .array_erasing(array_erasing),
        .read_data_undefined(read_data_undefined),
        .sector_contents_undefined(sector_contents_undefined),
        .page_contents_undefined(page_contents_undefined));
    fces_spi_host u_host (.core_clk(core_clk), .spi_sck(spi_sck), .spi_cs_b(spi_cs_b),
        .spi_si(spi_si));
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic chk(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk
    function automatic logic pick(input int w);
        return (w == 0) ? ready_busy_flag : erase_suspended_flag;
    endfunction : pick
    // polls status with a bound instead of sitting out the full erase time
    task automatic wait_for(input int w, input logic want);
        for (int i = 0; i < 3000 && pick(w) !== want; i++)
            @(negedge core_clk);
        chk("wait flag", want, pick(w));
    endtask : wait_for
    task automatic t_erase(input logic [7:0] op, input logic fail);
        erase_fail = fail;
        u_host.send(16'h0600, 8);
        chk("wel set", 1'b1, write_enable_latch);
        u_host.send({op, 8'ha5}, 16);
        wait_for(0, 1'b1);
        chk("erasing", 1'b1, array_erasing);
        chk("wel in erase", 1'b0, write_enable_latch);
        wait_for(0, 1'b0);
        chk("error flag", fail, erase_program_error_flag);
        erase_fail = 1'b0;
    endtask : t_erase
    task automatic t_reject();
        u_host.send(16'h6000, 8);
        repeat (20) @(negedge core_clk);
        chk("busy no wel", 1'b0, ready_busy_flag);
        for (int k = 0; k < 3; k++)
        begin
            any_sector_protected = (k == 1);
            any_sector_locked = (k == 2);
            u_host.send(16'h0600, 8);
            u_host.send(16'hc700, (k == 0) ? 12 : 8);
            repeat (20) @(negedge core_clk);
            chk("busy reject", 1'b0, ready_busy_flag);
            chk("wel reject", 1'b0, write_enable_latch);
        end
        any_sector_protected = 1'b0;
        any_sector_locked = 1'b0;
    endtask : t_reject
    task automatic t_suspend();
        u_host.send(16'hb000, 8);
        repeat (20) @(negedge core_clk);
        chk("idle suspend", 1'b0, erase_suspended_flag);
        u_host.send(16'h0600, 8);
        u_host.send(16'h6000, 8);
        wait_for(0, 1'b1);
        u_host.send(16'hb000, 12);
        repeat (20) @(negedge core_clk);
        chk("short suspend", 1'b0, erase_suspended_flag);
        chk("still busy", 1'b1, ready_busy_flag);
        u_host.send(16'hb0ff, 16);
        wait_for(1, 1'b1);
        chk("ready in suspend", 1'b0, ready_busy_flag);
        u_host.send(16'h0600, 8);
        u_host.send(16'h6000, 8);
        repeat (20) @(negedge core_clk);
        chk("no erase in suspend", 1'b0, ready_busy_flag);
        chk("wel kept", 1'b1, write_enable_latch);
        chk("still suspended", 1'b1, erase_suspended_flag);
        chk("read undefined", 1'b1, read_data_undefined);
        u_host.send(16'h0205, 16);
        chk("wel program abort", 1'b0, write_enable_latch);
        chk("no program", 1'b0, ready_busy_flag);
        chk("no program suspend", 1'b0, program_suspended_flag);
        soft_reset = 1'b1;
        @(negedge core_clk);
        soft_reset = 1'b0;
        repeat (4) @(negedge core_clk);
        chk("suspend cancelled", 1'b0, erase_suspended_flag);
        chk("block undefined", 1'b1, sector_contents_undefined);
        chk("page kept", 1'b0, page_contents_undefined);
        chk("read defined", 1'b0, read_data_undefined);
    endtask : t_suspend
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        summarize();
    end
    initial
    begin
        rst_b = 1'b0;
        {any_sector_protected, any_sector_locked, erase_fail, program_fail, soft_reset} = '0;
        read_sector = 5'h00;
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge core_clk);
        t_erase(fces_pkg::OP_CHIP_ERASE_A, 1'b0);
        t_erase(fces_pkg::OP_CHIP_ERASE_B, 1'b1);
        t_reject();
        t_suspend();
        summarize();
    end
endmodule : fces_chip_erase_tb
bind fces_chip_erase fces_chip_erase_chk #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .spi_cs_b(spi_cs_b),
    .any_sector_protected(any_sector_protected), .any_sector_locked(any_sector_locked),
    .erase_fail(erase_fail), .soft_reset(soft_reset),
    .write_enable_latch(write_enable_latch), .ready_busy_flag(ready_busy_flag),
    .erase_program_error_flag(erase_program_error_flag),
    .erase_suspended_flag(erase_suspended_flag),
    .protection_registers_locked_flag(protection_registers_locked_flag),
    .lockdown_enabled_flag(lockdown_enabled_flag), .array_erasing(array_erasing),
    .sector_contents_undefined(sector_contents_undefined));
